// >>> fbm_pkg.sv
package fbm_pkg;

    localparam int unsigned DW       = 36;
    localparam int unsigned DEPTH    = 256;
    localparam int unsigned AW       = 8;
    localparam int unsigned CW       = AW + 1;
    localparam int unsigned BYTE_W   = 9;
    localparam int unsigned WORD_W   = 18;

    localparam logic [CW-1:0] FIFO_DEPTH  = 9'h100;
    localparam logic [CW-1:0] CNT_ZERO    = 9'h000;
    localparam logic [CW-1:0] CNT_ONE     = 9'h001;
    localparam logic [DW-1:0] DATA_ZERO   = 36'h0;

    // index of the last piece of a word, per bus width
    localparam logic [1:0] LAST_LONG   = 2'h0;
    localparam logic [1:0] LAST_WORD   = 2'h1;
    localparam logic [1:0] LAST_BYTE   = 2'h3;
    localparam logic [1:0] PIECE_FIRST = 2'h0;
    localparam logic [1:0] PIECE_STEP  = 2'h1;

    typedef enum logic [1:0] {
        FBM_LONG,
        FBM_WORD,
        FBM_BYTE
    } fbm_width_e;

    typedef struct packed {
        logic          cs_n;
        logic          en;
        logic          wr;
        logic [DW-1:0] data;
    } fbm_port_a_s;

    typedef struct packed {
        logic cs_n;
        logic en;
        logic rd;
    } fbm_port_b_s;

    typedef struct packed {
        logic          endian;
        logic          bus_match;
        logic          size;
        logic [CW-1:0] ae_off;
        logic [CW-1:0] af_off;
    } fbm_straps_s;

    typedef struct packed {
        logic          big;
        fbm_width_e    width;
        logic [1:0]    last_piece;
        logic [CW-1:0] ae_off;
    } fbm_cfg_s;

endpackage : fbm_pkg

// >>> fbm_fifo_ports.sv
// What this block does
// - almost-empty low when words at or below offset
// - almost-full low when free at or below offset
// - full and almost-full change on write clock
// - empty and almost-empty change on read clock
// - endian high at reset: big-endian order
// - endian low at reset: little-endian order
// - after reset select pin picks timing mode
// - bus match low long word, high byte/word
// - port A transfer only with select low
// - port A data released while select high
// - port B transfer only with select low
// - port B data released while select high
// - standard mode: combined flag is empty
// - fall-through mode: combined flag is ready
// - port A is 36-bit two-way
// - port B 36-bit, upper lanes unused narrow
// - port enable high also needed for transfer
// - combined full flag: full or input ready
// - flags pass two stages in own domain
module fbm_fifo_ports (
    input  wire logic                   mclk_i,
    input  wire logic                   rstn_i,
    input  wire logic                   read_port_clock_i,
    input  wire logic                   write_port_select_n_i,
    input  wire logic                   write_port_enable_i,
    input  wire logic                   write_port_write_i,
    input  wire logic [fbm_pkg::DW-1:0] write_port_data_i,
    output logic      [fbm_pkg::DW-1:0] write_port_data_o,
    output logic                        write_port_data_oe_o,
    output logic                        full_input_ready_o,
    output logic                        almost_full_n_o,
    input  wire logic                   read_port_select_n_i,
    input  wire logic                   read_port_enable_i,
    input  wire logic                   read_port_read_i,
    input  wire logic [fbm_pkg::DW-1:0] read_port_data_i,
    output logic      [fbm_pkg::DW-1:0] read_port_data_o,
    output logic                        read_port_data_oe_o,
    output logic                        empty_output_ready_o,
    output logic                        almost_empty_n_o,
    input  wire logic                   endian_timing_select_i,
    input  wire logic                   bus_match_select_i,
    input  wire logic                   size_select_i,
    input  wire logic [fbm_pkg::CW-1:0] almost_empty_offset_i,
    input  wire logic [fbm_pkg::CW-1:0] almost_full_offset_i
);
    import fbm_pkg::*;

    function automatic logic [CW-1:0] bin2gray(input logic [CW-1:0] b);
        bin2gray = b ^ (b >> 1);
    endfunction : bin2gray

    function automatic logic [CW-1:0] gray2bin(input logic [CW-1:0] g);
        logic [CW-1:0] b;
        b = '0;
        b[CW-1] = g[CW-1];
        for (int i = CW - 2; i >= 0; i--)
        begin
            b[i] = b[i+1] ^ g[i];
        end
        gray2bin = b;
    endfunction : gray2bin

    // pick the piece of a stored word that goes out next
    function automatic logic [DW-1:0] piece_sel(input logic [DW-1:0] w,
                                                input logic [1:0]    p,
                                                input fbm_cfg_s      c);
        logic [1:0] k;
        k = '0;
        piece_sel = w;
        unique case (c.width)
            FBM_LONG: piece_sel = w;
            FBM_WORD:
            begin
                k = c.big ? (LAST_WORD - p) : p;
                piece_sel = DW'(w[k[0]*WORD_W +: WORD_W]);
            end
            FBM_BYTE:
            begin
                k = c.big ? (LAST_BYTE - p) : p;
                piece_sel = DW'(w[k*BYTE_W +: BYTE_W]);
            end
            default: piece_sel = w;
        endcase
    endfunction : piece_sel

    // write-clock domain (port A)
    fbm_port_a_s   a_meta_q;
    fbm_port_a_s   a_q;
    fbm_straps_s   st_meta_q;
    fbm_straps_s   st_q;
    fbm_cfg_s      cfg_q;
    logic [CW-1:0] af_off_q;
    logic [CW-1:0] wbin_q;
    logic [CW-1:0] wgray_q;
    logic [CW-1:0] rgray_meta_q;
    logic [CW-1:0] rgray_w_q;
    logic [CW-1:0] rgray_q;
    logic          full_n_q;
    logic          af_n_q;
    logic [DW-1:0] mem_q [DEPTH];

    wire fbm_port_a_s   a_pin     = '{cs_n: write_port_select_n_i, en: write_port_enable_i,
                                      wr: write_port_write_i, data: write_port_data_i};
    wire fbm_straps_s   st_pin    = '{endian: endian_timing_select_i,
                                      bus_match: bus_match_select_i, size: size_select_i,
                                      ae_off: almost_empty_offset_i,
                                      af_off: almost_full_offset_i};
    wire logic [CW-1:0] rbin_w    = gray2bin(rgray_w_q);
    wire logic [CW-1:0] count_w   = wbin_q - rbin_w;
    wire logic          write_go  = !a_q.cs_n && a_q.en && a_q.wr
                                    && (count_w != FIFO_DEPTH);
    wire logic [CW-1:0] wbin_d    = write_go ? (wbin_q + CNT_ONE) : wbin_q;
    wire logic [CW-1:0] count_wd  = wbin_d - rbin_w;
    wire logic [CW-1:0] free_wd   = FIFO_DEPTH - count_wd;
    wire fbm_width_e    width_d   = !st_q.bus_match ? FBM_LONG :
                                    (st_q.size ? FBM_BYTE : FBM_WORD);
    wire logic [1:0]    last_d    = !st_q.bus_match ? LAST_LONG :
                                    (st_q.size ? LAST_BYTE : LAST_WORD);

    always_ff @(posedge mclk_i)
    begin
        a_meta_q     <= a_pin;
        a_q          <= a_meta_q;
        st_meta_q    <= st_pin;
        st_q         <= st_meta_q;
        rgray_meta_q <= rgray_q;
        rgray_w_q    <= rgray_meta_q;
    end

    // endian, width and offsets are caught while reset is held
    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            cfg_q    <= '{big: st_q.endian, width: width_d,
                          last_piece: last_d, ae_off: st_q.ae_off};
            af_off_q <= st_q.af_off;
            wbin_q   <= CNT_ZERO;
            wgray_q  <= CNT_ZERO;
            full_n_q <= 1'b0;
            af_n_q   <= 1'b1;
        end
        else
        begin
            wbin_q   <= wbin_d;
            wgray_q  <= bin2gray(wbin_d);
            full_n_q <= (count_wd != FIFO_DEPTH);
            af_n_q   <= !(free_wd <= af_off_q);
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (write_go)
        begin
            mem_q[wbin_q[AW-1:0]] <= a_q.data;
        end
    end

    // port A drives only for reads, which carry no FIFO data
    assign write_port_data_o    = DATA_ZERO;
    assign write_port_data_oe_o = !a_q.cs_n && !a_q.wr;
    assign full_input_ready_o   = full_n_q;
    assign almost_full_n_o      = af_n_q;

    // read-clock domain (port B)
    logic          rrst_meta_q;
    logic          rrstn_q;
    fbm_port_b_s   b_meta_q;
    fbm_port_b_s   b_q;
    logic          tm_meta_q;
    logic          tm_q;
    fbm_cfg_s      cfg_meta_q;
    fbm_cfg_s      cfg_r_q;
    logic [CW-1:0] wgray_meta_q;
    logic [CW-1:0] wgray_r_q;
    logic [CW-1:0] rbin_q;
    logic [CW-1:0] fbin_q;
    logic [DW-1:0] word_q;
    logic          wvalid_q;
    logic [1:0]    piece_q;
    logic [DW-1:0] rd_data_q;
    logic          eor_q;
    logic          ae_n_q;

    wire fbm_port_b_s   b_pin     = '{cs_n: read_port_select_n_i, en: read_port_enable_i,
                                      rd: read_port_read_i};
    wire logic          fall_through_mode      = !tm_q;
    wire logic [CW-1:0] wbin_r    = gray2bin(wgray_r_q);
    wire logic          mem_has   = (wbin_r != rbin_q);
    wire logic          rd_go     = !b_q.cs_n && b_q.en && b_q.rd && wvalid_q;
    wire logic          last      = (piece_q == cfg_r_q.last_piece);
    wire logic          consume   = rd_go && last;
    wire logic          pop       = mem_has && (!wvalid_q || consume);
    wire logic [DW-1:0] word_d    = pop ? mem_q[rbin_q[AW-1:0]] : word_q;
    wire logic          wvalid_d  = pop || (wvalid_q && !consume);
    wire logic [1:0]    piece_d   = consume ? PIECE_FIRST :
                                    (rd_go ? (piece_q + PIECE_STEP) : piece_q);
    wire logic [CW-1:0] rbin_d    = pop ? (rbin_q + CNT_ONE) : rbin_q;
    // slot freed only once the held word is fully read, so depth stays exact
    wire logic [CW-1:0] fbin_d    = consume ? (fbin_q + CNT_ONE) : fbin_q;
    wire logic [CW-1:0] words_d   = (wbin_r - rbin_d) + (wvalid_d ? CNT_ONE : CNT_ZERO);
    wire logic [DW-1:0] fall_data = wvalid_d ? piece_sel(word_d, piece_d, cfg_r_q) : rd_data_q;
    wire logic [DW-1:0] std_data  = rd_go ? piece_sel(word_q, piece_q, cfg_r_q) : rd_data_q;

    always_ff @(posedge read_port_clock_i)
    begin
        rrst_meta_q  <= rstn_i;
        rrstn_q      <= rrst_meta_q;
        b_meta_q     <= b_pin;
        b_q          <= b_meta_q;
        tm_meta_q    <= endian_timing_select_i;
        tm_q         <= tm_meta_q;
        cfg_meta_q   <= cfg_q;
        cfg_r_q      <= cfg_meta_q;
        wgray_meta_q <= wgray_q;
        wgray_r_q    <= wgray_meta_q;
    end

    always_ff @(posedge read_port_clock_i)
    begin
        if (!rrstn_q)
        begin
            rbin_q    <= CNT_ZERO;
            rgray_q   <= CNT_ZERO;
            fbin_q    <= CNT_ZERO;
            word_q    <= DATA_ZERO;
            wvalid_q  <= 1'b0;
            piece_q   <= PIECE_FIRST;
            rd_data_q <= DATA_ZERO;
            eor_q     <= 1'b0;
            ae_n_q    <= 1'b0;
        end
        else
        begin
            rbin_q    <= rbin_d;
            fbin_q    <= fbin_d;
            rgray_q   <= bin2gray(fbin_d);
            word_q    <= word_d;
            wvalid_q  <= wvalid_d;
            piece_q   <= piece_d;
            rd_data_q <= fall_through_mode ? fall_data : std_data;
            eor_q     <= wvalid_d;
            ae_n_q    <= !(words_d <= cfg_r_q.ae_off);
        end
    end

    assign read_port_data_o     = rd_data_q;
    assign read_port_data_oe_o  = !b_q.cs_n && b_q.rd;
    assign empty_output_ready_o = eor_q;
    assign almost_empty_n_o     = ae_n_q;

    // checks, write domain
    a_af_level: assert property (
        @(posedge mclk_i) disable iff (!rstn_i)
        (free_wd <= af_off_q) |=> !almost_full_n_o)
        else $error("almost-full not low at threshold");

    a_full_flag: assert property (
        @(posedge mclk_i) disable iff (!rstn_i)
        (count_wd == FIFO_DEPTH) |=> !full_input_ready_o)
        else $error("full flag not low when full");

    a_full_hold: assert property (
        @(posedge mclk_i) disable iff (!rstn_i)
        (count_w == FIFO_DEPTH) |=> $stable(wbin_q))
        else $error("write pointer moved while full");

    a_wr_select: assert property (
        @(posedge mclk_i) disable iff (!rstn_i)
        (a_q.cs_n || !a_q.en) |=> ($past(wbin_q) == wbin_q))
        else $error("write taken without select and enable");

    a_a_release: assert property (
        @(posedge mclk_i) disable iff (!rstn_i)
        $past(write_port_select_n_i, 2) |-> !write_port_data_oe_o)
        else $error("port A driven while deselected");

    // checks, read domain
    sequence s_read_piece;
        rd_go && !last;
    endsequence

    sequence s_read_last;
        rd_go && last;
    endsequence

    a_ae_level: assert property (
        @(posedge read_port_clock_i) disable iff (!rrstn_q)
        (words_d <= cfg_r_q.ae_off) |=> !almost_empty_n_o)
        else $error("almost-empty not low at threshold");

    a_rd_select: assert property (
        @(posedge read_port_clock_i) disable iff (!rrstn_q)
        b_q.cs_n |=> $stable(piece_q) && ($past(wvalid_q) == wvalid_q || wvalid_q))
        else $error("read advanced without select");

    a_b_release: assert property (
        @(posedge read_port_clock_i) disable iff (!rrstn_q)
        $past(read_port_select_n_i, 2) |-> !read_port_data_oe_o)
        else $error("port B driven while deselected");

    a_piece_walk: assert property (
        @(posedge read_port_clock_i) disable iff (!rrstn_q)
        s_read_piece |=> (piece_q == $past(piece_q) + PIECE_STEP) && wvalid_q)
        else $error("piece index did not advance");

    a_last_piece: assert property (
        @(posedge read_port_clock_i) disable iff (!rrstn_q)
        s_read_last |=> (piece_q == PIECE_FIRST))
        else $error("piece index not reset after last piece");

    a_long_pop: assert property (
        @(posedge read_port_clock_i) disable iff (!rrstn_q)
        (cfg_r_q.width == FBM_LONG) |-> (piece_q == PIECE_FIRST))
        else $error("long word mode split a word");

    a_big_first: assert property (
        @(posedge read_port_clock_i) disable iff (!rrstn_q)
        (fall_through_mode && wvalid_q && cfg_r_q.big && cfg_r_q.width == FBM_BYTE
            && piece_q == PIECE_FIRST && !rd_go && !pop)
        |=> (read_port_data_o[BYTE_W-1:0] == word_q[DW-1 -: BYTE_W]))
        else $error("big-endian byte order wrong");

    a_little_first: assert property (
        @(posedge read_port_clock_i) disable iff (!rrstn_q)
        (fall_through_mode && wvalid_q && !cfg_r_q.big && cfg_r_q.width == FBM_WORD
            && piece_q == PIECE_FIRST && !rd_go && !pop)
        |=> (read_port_data_o == DW'(word_q[WORD_W-1:0])))
        else $error("little-endian word order wrong");

    a_ready_flag: assert property (
        @(posedge read_port_clock_i) disable iff (!rrstn_q)
        (fall_through_mode && !wvalid_d) |=> !empty_output_ready_o)
        else $error("output ready high with no data held");

    a_empty_flag: assert property (
        @(posedge read_port_clock_i) disable iff (!rrstn_q)
        (!fall_through_mode && words_d == CNT_ZERO) |=> !empty_output_ready_o && !almost_empty_n_o)
        else $error("empty flag high while FIFO empty");

endmodule : fbm_fifo_ports

// >>> fbm_reader_model.sv
module fbm_reader_model (
    input  wire logic                   read_port_clock_i,
    input  wire logic                   empty_output_ready_i,
    input  wire logic [fbm_pkg::DW-1:0] read_port_data_i,
    output logic                        read_port_select_n_o,
    output logic                        read_port_enable_o,
    output logic                        read_port_read_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import fbm_pkg::*;

    initial
    begin
        read_port_select_n_o = 1'b0;
        read_port_enable_o   = 1'b0;
        read_port_read_o     = 1'b1;
    end

    task automatic select(input logic sel_n);
        @(posedge read_port_clock_i);
        read_port_select_n_o <= sel_n;
    endtask : select

    // waits for a word, then one enable pulse with read held high; gap models a slow reader
    task automatic take(input logic fall_through_mode, input int gap, output logic [DW-1:0] piece,
                        output logic ok);
        int n;
        ok    = 1'b0;
        piece = DATA_ZERO;
        for (n = 0; n < 64 && !ok; n++)
        begin
            @(posedge read_port_clock_i);
            ok = (empty_output_ready_i === 1'b1);
        end
        // fall-through shows the piece before the read, standard after it
        if (fall_through_mode)
            piece = read_port_data_i;
        read_port_enable_o <= ok;
        @(posedge read_port_clock_i);
        read_port_enable_o <= 1'b0;
        repeat (4 + gap) @(posedge read_port_clock_i);
        if (!fall_through_mode)
            piece = read_port_data_i;
    endtask : take
endmodule : fbm_reader_model

// >>> fbm_fifo_ports_tb.sv
module fbm_fifo_ports_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fbm_pkg::*;

    logic          mclk, rstn, rclk, wsel_n, wen, wwr, ets, bms, szs, fall_through_mode, big;
    logic [DW-1:0] wdata, wq, rq;
    logic [CW-1:0] ae_off, af_off;
    logic          woe, fir, afn, roe, eor, aen, rsel_n, ren, rrd;
    logic [DW-1:0] exp_q[$];
    logic [3:0]    cfg_tab[6] = '{4'h9, 4'h4, 4'hE, 4'h7, 4'h0, 4'hD};
    int            bad_count, checks, np, pw;

    fbm_fifo_ports DUT (
        .mclk_i(mclk), .rstn_i(rstn), .read_port_clock_i(rclk),
        .write_port_select_n_i(wsel_n), .write_port_enable_i(wen),
        .write_port_write_i(wwr), .write_port_data_i(wdata), .write_port_data_o(wq),
        .write_port_data_oe_o(woe), .full_input_ready_o(fir), .almost_full_n_o(afn),
        .read_port_select_n_i(rsel_n), .read_port_enable_i(ren), .read_port_read_i(rrd),
        .read_port_data_i(DATA_ZERO), .read_port_data_o(rq), .read_port_data_oe_o(roe),
        .empty_output_ready_o(eor), .almost_empty_n_o(aen),
        .endian_timing_select_i(ets), .bus_match_select_i(bms), .size_select_i(szs),
        .almost_empty_offset_i(ae_off), .almost_full_offset_i(af_off)
    );

    fbm_reader_model rdr (
        .read_port_clock_i(rclk), .empty_output_ready_i(eor), .read_port_data_i(rq),
        .read_port_select_n_o(rsel_n), .read_port_enable_o(ren), .read_port_read_o(rrd)
    );

    always #5 mclk = ~mclk;
    always #62.5 rclk = ~rclk;

    task automatic cmp_data(input string what, input logic [DW-1:0] e, input logic [DW-1:0] g);
        checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask : cmp_data

    task automatic cmp_bit(input string what, input logic e, input logic g);
        checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %s expected %b seen %b", what, e, g);
        end
    endtask : cmp_bit

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    task automatic settle(input int n);
        repeat (n) @(posedge rclk);
        // write-side pins need two sync edges before the outputs follow
        repeat (3) @(posedge mclk);
        @(negedge mclk);
    endtask : settle

    // straps held through reset, then the select pin takes the timing level
    task automatic do_reset(input logic b, input logic bm, input logic sz, input logic std);
        @(posedge mclk);
        rstn   <= 1'b0;
        ets    <= b;
        bms    <= bm;
        szs    <= sz;
        ae_off <= CW'($urandom_range(6, 2));
        af_off <= CW'($urandom_range(6, 2));
        exp_q.delete();
        repeat (10) @(posedge rclk);
        @(posedge mclk);
        rstn <= 1'b1;
        ets  <= std;
        big  = b;
        fall_through_mode = !std;
        np   = !bm ? 1 : (sz ? 4 : 2);
        pw   = !bm ? DW : (sz ? BYTE_W : WORD_W);
        settle(4);
    endtask : do_reset

    task automatic put_n(input int n, input logic sel_n, input logic en);
        logic [63:0] r;
        for (int i = 0; i < n; i++)
        begin
            r = {$urandom, $urandom};
            @(posedge mclk);
            wsel_n <= sel_n;
            wen    <= en;
            wwr    <= 1'b1;
            wdata  <= r[DW-1:0];
            if (!sel_n && en && exp_q.size() < DEPTH)
                exp_q.push_back(r[DW-1:0]);
        end
        @(posedge mclk);
        wen    <= 1'b0;
        wsel_n <= 1'b0;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
    endtask : put_n

    function automatic logic [DW-1:0] piece_of(input logic [DW-1:0] w, input int k);
        return (w >> ((big ? np - 1 - k : k) * pw)) & ((36'h1 << pw) - 36'h1);
    endfunction : piece_of

    task automatic get_word(input int gap);
        logic [DW-1:0] w;
        logic [DW-1:0] piece;
        logic          ok;
        w = exp_q.pop_front();
        for (int k = 0; k < np; k++)
        begin
            rdr.take(fall_through_mode, gap, piece, ok);
            cmp_bit("word available", 1'b1, ok);
            if (ok !== 1'b1)
                report_and_stop();
            cmp_data("read piece", piece_of(w, k), piece);
        end
    endtask : get_word

    initial
    begin
        {mclk, rclk, rstn, wsel_n, wen, wwr, ets, bms, szs} = 9'h020;
        {wdata, ae_off, af_off} = '0;
        void'($urandom(42664));
        repeat (16) @(posedge mclk);
        for (int i = 0; i < 6; i++)
        begin
            do_reset(cfg_tab[i][3], cfg_tab[i][2], cfg_tab[i][1], cfg_tab[i][0]);
            cmp_bit("empty_output_ready", 1'b0, eor);
            cmp_bit("almost_empty_n", 1'b0, aen);
            cmp_bit("full_input_ready", 1'b1, fir);
            cmp_bit("almost_full_n", 1'b1, afn);
            put_n(1 + $urandom_range(7), 1'b0, 1'b1);
            settle(8);
            cmp_bit("empty_output_ready", 1'b1, eor);
            while (exp_q.size() > 0)
                get_word($urandom_range(2));
            settle(8);
            cmp_bit("empty_output_ready", 1'b0, eor);
        end
        do_reset(1'b0, 1'b0, 1'b0, 1'b1);
        @(posedge mclk);
        wwr <= 1'b0;
        settle(1);
        cmp_bit("write_port_data_oe", 1'b1, woe);
        cmp_data("write_port_data", DATA_ZERO, wq);
        @(posedge mclk);
        wsel_n <= 1'b1;
        settle(1);
        cmp_bit("write_port_data_oe", 1'b0, woe);
        cmp_bit("read_port_data_oe", 1'b1, roe);
        rdr.select(1'b1);
        settle(4);
        cmp_bit("read_port_data_oe", 1'b0, roe);
        put_n(2, 1'b1, 1'b1);
        put_n(2, 1'b0, 1'b0);
        settle(8);
        cmp_bit("empty_output_ready", 1'b0, eor);
        put_n(int'(ae_off), 1'b0, 1'b1);
        settle(8);
        cmp_bit("almost_empty_n", 1'b0, aen);
        put_n(1, 1'b0, 1'b1);
        settle(8);
        cmp_bit("almost_empty_n", 1'b1, aen);
        put_n(int'(DEPTH) - int'(af_off) - 1 - exp_q.size(), 1'b0, 1'b1);
        cmp_bit("almost_full_n", 1'b1, afn);
        put_n(1, 1'b0, 1'b1);
        cmp_bit("almost_full_n", 1'b0, afn);
        put_n(int'(DEPTH) - 1 - exp_q.size(), 1'b0, 1'b1);
        cmp_bit("full_input_ready", 1'b1, fir);
        put_n(4, 1'b0, 1'b1);
        cmp_bit("full_input_ready", 1'b0, fir);
        rdr.select(1'b0);
        while (exp_q.size() > 0)
            get_word(0);
        settle(8);
        cmp_bit("empty_output_ready", 1'b0, eor);
        cmp_bit("almost_empty_n", 1'b0, aen);
        cmp_bit("full_input_ready", 1'b1, fir);
        report_and_stop();
    end
endmodule : fbm_fifo_ports_tb
